// [core/cih_ctrl.sv]
// cascaded interrupt handling: two eight-line controllers, second cascaded into master
// assumes request pins are asynchronous; eoi/ack/latch strobes are sys_clk pulses
// Operation
// [RULE1] pci lines are level sensitive and isa lines are edge sensitive.
// [RULE2] an end-of-interrupt command clears the in-service bit of the line being serviced.
// [RULE3] the end-of-interrupt command is honoured whatever the request line level.
// [RULE4] a level line still active at end-of-interrupt is raised again as a new interrupt.
// [RULE5] software clears the source, waits, sends end-of-interrupt, waits, then re-enables.
// [RULE6] the cascade request line is routed to the redirected input of the second controller.
// [RULE7] the redirected handler ends at the second controller, then the cascade handler ends.
// [RULE8] an in-progress latch is readable and cleared by the read or by an explicit reset.
// [RULE9] the second controller output drives the master cascade input.
`timescale 1ns/1ps
`default_nettype none
module cih_ctrl
   import cih_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  reset_n,
   input  wire logic [NUM_LINES-1:0]  master_req_pin,
   input  wire logic [NUM_LINES-1:0]  slave_req_pin,
   input  wire logic                  cascade_request_line,
   input  wire logic                  int_ack,
   input  wire logic                  eoi_master,
   input  wire logic                  eoi_slave,
   input  wire logic                  latch_read,
   input  wire logic                  latch_clear,
   input  wire logic                  latch_read_clears,
   output logic                       cpu_int,
   output logic [VEC_W-1:0]           vector_out,
   output logic                       progress_latch,
   output logic [NUM_LINES-1:0]       master_in_service,
   output logic [NUM_LINES-1:0]       slave_in_service
);
   import cih_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // synchronisers
   logic [NUM_LINES-1:0] m_s1_reg, m_s2_reg, m_prev_reg;
   logic [NUM_LINES-1:0] s_s1_reg, s_s2_reg, s_prev_reg;
   logic                 c_s1_reg, c_s2_reg;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         m_s1_reg <= RESET_ZERO8;
         m_s2_reg <= RESET_ZERO8;
         s_s1_reg <= RESET_ZERO8;
         s_s2_reg <= RESET_ZERO8;
         c_s1_reg <= 1'b0;
         c_s2_reg <= 1'b0;
      end else begin
         m_s1_reg <= master_req_pin;
         m_s2_reg <= m_s1_reg;
         s_s1_reg <= slave_req_pin;
         s_s2_reg <= s_s1_reg;
         c_s1_reg <= cascade_request_line;
         c_s2_reg <= c_s1_reg;
      end
   end

   // cascade line folded onto the redirected input of the second controller
   logic [NUM_LINES-1:0] s_level;
   always_comb begin
      s_level = s_s2_reg;
      s_level[REDIRECT_LINE] = s_s2_reg[REDIRECT_LINE] | c_s2_reg; // RULE6
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         m_prev_reg <= RESET_ZERO8;
         s_prev_reg <= RESET_ZERO8;
      end else begin
         m_prev_reg <= m_s2_reg;
         s_prev_reg <= s_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request capture
   logic [NUM_LINES-1:0] m_irr_reg, s_irr_reg;
   logic [NUM_LINES-1:0] m_isr_reg, s_isr_reg;
   logic [NUM_LINES-1:0] m_edge, s_edge, m_raw, s_raw;
   assign m_edge = m_s2_reg & ~m_prev_reg;
   assign s_edge = s_level & ~s_prev_reg;
   // level lines request while high and not in service, so one still high after
   // eoi is seen again at once
   assign m_raw = (MASTER_LEVEL & m_s2_reg & ~m_isr_reg) | (~MASTER_LEVEL & m_edge); // RULE1 RULE4
   assign s_raw = (SLAVE_LEVEL & s_level & ~s_isr_reg) | (~SLAVE_LEVEL & s_edge); // RULE1 RULE4

   // highest priority = lowest pending index
   function automatic logic [LINE_W:0] cih_pick(input logic [NUM_LINES-1:0] v);
      logic [LINE_W:0] r;
      r = '0;
      for (int i = NUM_LINES-1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, LINE_W'(i)};
         end
      end
      return r;
   endfunction : cih_pick

   logic [NUM_LINES-1:0] m_irr_eff, m_svc_mask;
   logic [LINE_W:0]      m_pick, s_pick;
   logic                 slave_out;
   assign s_pick    = cih_pick(s_irr_reg);
   assign slave_out = s_pick[LINE_W]; // RULE9
   always_comb begin
      m_irr_eff = m_irr_reg;
      m_irr_eff[CASCADE_LINE] = slave_out; // RULE9
   end
   assign m_pick = cih_pick(m_irr_eff);

   logic [LINE_W-1:0] m_top, s_top;
   logic [LINE_W:0]   m_isr_pick, s_isr_pick;
   assign m_isr_pick = cih_pick(m_isr_reg);
   assign s_isr_pick = cih_pick(s_isr_reg);
   assign m_top      = m_isr_pick[LINE_W-1:0];
   assign s_top      = s_isr_pick[LINE_W-1:0];
   logic ack_master, ack_slave;
   assign ack_master = int_ack & m_pick[LINE_W];
   assign ack_slave  = ack_master & (m_pick[LINE_W-1:0] == CASCADE_LINE);
   logic [NUM_LINES-1:0] m_ack_mask, s_ack_mask;
   assign m_ack_mask = ack_master ? (8'h01 << m_pick[LINE_W-1:0]) : RESET_ZERO8;
   assign s_ack_mask = ack_slave ? (8'h01 << s_pick[LINE_W-1:0]) : RESET_ZERO8;

   // on edge lines set wins over clear: a new edge in the ack cycle stays pending
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         m_irr_reg <= RESET_ZERO8;
      end else begin
         // level lines are not latched: acknowledge drops them, else one
         // assertion would be taken again before the in-service bit shows
         m_irr_reg <= ((m_irr_reg & ~MASTER_LEVEL & ~m_ack_mask) | m_raw)
                      & ~(MASTER_LEVEL & m_ack_mask); // RULE1 RULE4
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s_irr_reg <= RESET_ZERO8;
      end else begin
         s_irr_reg <= ((s_irr_reg & ~SLAVE_LEVEL & ~s_ack_mask) | s_raw)
                      & ~(SLAVE_LEVEL & s_ack_mask); // RULE1 RULE4
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // in-service state; eoi takes no notice of the request level
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         m_isr_reg <= RESET_ZERO8;
      end else begin
         m_isr_reg <= (m_isr_reg & ~(eoi_master && m_isr_reg != RESET_ZERO8 ?
                                     (8'h01 << m_top) : RESET_ZERO8)) // RULE2 RULE3
                      | (ack_master ? (8'h01 << m_pick[LINE_W-1:0]) : RESET_ZERO8);
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s_isr_reg <= RESET_ZERO8;
      end else begin
         s_isr_reg <= (s_isr_reg & ~(eoi_slave && s_isr_reg != RESET_ZERO8 ?
                                     (8'h01 << s_top) : RESET_ZERO8)) // RULE2 RULE3
                      | (ack_slave ? (8'h01 << s_pick[LINE_W-1:0]) : RESET_ZERO8);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cpu_int           <= 1'b0;
         vector_out        <= RESET_ZERO8;
         master_in_service <= RESET_ZERO8;
         slave_in_service  <= RESET_ZERO8;
      end else begin
         cpu_int           <= m_pick[LINE_W] & ~ack_master;
         master_in_service <= m_isr_reg;
         slave_in_service  <= s_isr_reg;
         if (ack_slave) begin
            vector_out <= SLAVE_BASE + VEC_W'(s_pick[LINE_W-1:0]); // RULE6
         end else if (ack_master) begin
            vector_out <= MASTER_BASE + VEC_W'(m_pick[LINE_W-1:0]);
         end
      end
   end

   // set on acknowledge; read-clear only where the source works that way
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         progress_latch <= 1'b0;
      end else if (ack_master) begin
         progress_latch <= 1'b1; // RULE8
      end else if (latch_clear || (latch_read && latch_read_clears)) begin
         progress_latch <= 1'b0; // RULE8
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_eoi_clears_isr : assert property (@(posedge sys_clk) disable iff (!reset_n)
      eoi_master && !ack_master && $onehot(m_isr_reg) |=> m_isr_reg == RESET_ZERO8) // RULE2
      else $error("eoi did not clear master in-service bit");
   a_level_rearm : assert property (@(posedge sys_clk) disable iff (!reset_n)
      eoi_slave && !ack_slave && s_isr_reg == 8'h20 && s_level[5] ##1 s_level[5]
      |=> s_irr_reg[5]) // RULE4
      else $error("level line not raised again after eoi");
   a_edge_once : assert property (@(posedge sys_clk) disable iff (!reset_n)
      !ack_master && m_edge[3] |=> m_irr_reg[3]) // RULE1
      else $error("edge request lost");
   a_cascade_route : assert property (@(posedge sys_clk) disable iff (!reset_n)
      c_s2_reg && !s_prev_reg[REDIRECT_LINE] && !ack_slave |=> s_irr_reg[REDIRECT_LINE]) // RULE6
      else $error("cascade line not routed to redirected input");
   a_slave_reaches_cpu : assert property (@(posedge sys_clk) disable iff (!reset_n)
      slave_out && !int_ack |=> cpu_int) // RULE9
      else $error("second controller request did not reach processor");
   a_latch_clear : assert property (@(posedge sys_clk) disable iff (!reset_n)
      latch_clear && !ack_master |=> !progress_latch) // RULE8
      else $error("progress latch not cleared");
   a_latch_set : assert property (@(posedge sys_clk) disable iff (!reset_n)
      ack_master |=> progress_latch ##0 $past(ack_master)) // RULE8
      else $error("progress latch not set on acknowledge");
   a_eoi_any_level : assert property (@(posedge sys_clk) disable iff (!reset_n)
      eoi_slave && !ack_slave && s_isr_reg == 8'h02 |=> !s_isr_reg[1]) // RULE3
      else $error("eoi ignored while request active");
endmodule : cih_ctrl
`default_nettype wire

// [core/cih_pkg.sv]
// package for the cascaded interrupt handling block
// assumes one 20 MHz system clock and a synchronous active-low reset
package cih_pkg;
   localparam int          NUM_LINES      = 8;
   localparam int          LINE_W         = 3;
   localparam int          VEC_W          = 8;
   // master base 08h, second controller base 70h
   localparam logic [7:0]  MASTER_BASE    = 8'h08;
   localparam logic [7:0]  SLAVE_BASE     = 8'h70;
   localparam logic [2:0]  CASCADE_LINE   = 3'h2;
   localparam logic [2:0]  REDIRECT_LINE  = 3'h1;
   localparam logic [7:0]  RESET_ZERO8    = 8'h00;
   // line types: one bit per line, 1 = level sensitive (shared pci sources)
   localparam logic [7:0]  MASTER_LEVEL   = 8'h00;
   localparam logic [7:0]  SLAVE_LEVEL    = 8'hF0;
   typedef enum logic [1:0] {
      CIH_TARGET_MASTER,
      CIH_TARGET_SLAVE
   } cih_target_type;
endpackage : cih_pkg

// [testbench/cih_cpu_model.sv]
// processor model: acknowledges every request the controller raises
// assumes cpu_int stays high until an acknowledge is taken
`timescale 1ns/1ps
`default_nettype none
module cih_cpu_model (
   input  wire logic  sys_clk,
   input  wire logic  reset_n,
   input  wire logic  cpu_int,
   output logic       int_ack,
   output int         ack_count
);
   import cih_pkg::*;
   // one-cycle acknowledge; dropped half a cycle after cpu_int falls
   always @(negedge sys_clk) begin
      if (!reset_n || int_ack) begin
         int_ack <= 1'b0;
      end else begin
         int_ack <= cpu_int;
      end
   end
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         ack_count <= 0;
      end else if (int_ack && cpu_int) begin
         ack_count <= ack_count + 1;
      end
   end
endmodule : cih_cpu_model
`default_nettype wire

// [testbench/tb_top.sv]
// bench for the cascaded interrupt controller with a processor model
// assumes inputs change on the falling edge of sys_clk
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cih_pkg::*;
   logic sys_clk = 0, reset_n = 0, ack, cpu_int, latch, rd_clr = 0;
   logic [7:0] mreq = 0, sreq = 0, vec, mis, sis;
   logic casc = 0, eoi_m = 0, eoi_s = 0, l_rd = 0, l_clr = 0;
   int err_count = 0, compares = 0, acks, cycles = 0;
   always #25 sys_clk = ~sys_clk;
   cih_ctrl uut (.sys_clk(sys_clk), .reset_n(reset_n), .master_req_pin(mreq),
      .slave_req_pin(sreq), .cascade_request_line(casc), .int_ack(ack),
      .eoi_master(eoi_m), .eoi_slave(eoi_s), .latch_read(l_rd), .latch_clear(l_clr),
      .latch_read_clears(rd_clr), .cpu_int(cpu_int), .vector_out(vec),
      .progress_latch(latch), .master_in_service(mis), .slave_in_service(sis));
   cih_cpu_model cpu (.sys_clk(sys_clk), .reset_n(reset_n), .cpu_int(cpu_int),
      .int_ack(ack), .ack_count(acks));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic pulse(input int k);
      @(negedge sys_clk);
      {l_clr, l_rd, eoi_s, eoi_m} = 4'h1 << k;
      @(negedge sys_clk);
      {l_clr, l_rd, eoi_s, eoi_m} = 4'h0;
   endtask : pulse
   task automatic wait_ack(input int n);
      for (int i = 0; i < 40 && acks != n; i++) @(negedge sys_clk);
      repeat (2) @(negedge sys_clk);
   endtask : wait_ack
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////
   task automatic t_edge();
      mreq[3] = 1'b1;
      wait_ack(1);
      chk("vector", MASTER_BASE + 8'h03, vec);
      chk("master isr", 8'h08, mis);
      pulse(2);
      chk("latch kept", 8'h01, {7'h0, latch});
      pulse(3);
      chk("latch reset", 8'h00, {7'h0, latch});
      pulse(0);
      repeat (12) @(negedge sys_clk);
      chk("master isr", 8'h00, mis);
      chk("no repeat", 8'h01, 8'(acks));
      chk("cpu int idle", 8'h00, {7'h0, cpu_int});
      mreq[3] = 1'b0;
      $display("test edge done");
   endtask : t_edge
   task automatic t_level();
      sreq[5] = 1'b1;
      wait_ack(2);
      chk("vector", SLAVE_BASE + 8'h05, vec);
      chk("slave isr", 8'h20, sis);
      chk("cascade isr", 8'h04, mis);
      pulse(1);
      pulse(0);
      wait_ack(3);
      chk("re-raised", 8'h03, 8'(acks));
      chk("slave isr", 8'h20, sis);
      sreq[5] = 1'b0;
      repeat (4) @(negedge sys_clk);
      pulse(1);
      pulse(0);
      repeat (12) @(negedge sys_clk);
      chk("isr", 8'h00, mis | sis);
      chk("quiet", 8'h03, 8'(acks));
      $display("test level done");
   endtask : t_level
   task automatic t_cascade();
      rd_clr = 1'b1;
      casc = 1'b1;
      wait_ack(4);
      chk("vector", SLAVE_BASE + 8'(REDIRECT_LINE), vec);
      chk("slave isr", 8'h02, sis);
      chk("cascade isr", 8'h04, mis);
      pulse(2);
      chk("latch read", 8'h00, {7'h0, latch});
      pulse(1);
      casc = 1'b0;
      repeat (4) @(negedge sys_clk);
      pulse(0);
      repeat (3) @(negedge sys_clk);
      chk("isr", 8'h00, mis | sis);
      chk("cpu int quiet", 8'h00, {7'h0, cpu_int});
      $display("test cascade done");
   endtask : t_cascade
   ////////////////////////////////////////////////////////////
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      repeat (3) @(negedge sys_clk);
      reset_n = 1'b1;
      t_edge();
      t_level();
      t_cascade();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
